// ### hw/low_voltage_detect_control.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - bit 7 sticky supply warning flag
// - warning trip or low after reset sets flag
// - ack bit 6 clears flag once warning gone
// - irq enable bit 5 requests interrupt on flag
// - write-once reset enable forces reset on detect
// - stop enable keeps detection running in stop
// - write-once detect enable gates detection logic
// - bit 0 enables bandgap reference buffer
// - write-once bits take first write only
module low_voltage_detect_control (
  input wire logic clock,
  input wire logic rst,
  input wire logic [supply_mon_pkg::ADDR_W-1:0] addr,
  input wire logic [supply_mon_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [supply_mon_pkg::DATA_W-1:0] rdata,
  input wire logic supply_warn_trip,
  input wire logic supply_drop_detect,
  input wire logic stop_mode,
  output logic supply_warning_irq,
  output logic chip_reset_req,
  output logic detect_active,
  output logic reference_buffer_en
);
  // ==========================================================
  // decode
  logic wr_hit; // write to the control register
  logic rd_hit; // read of the control register
  assign wr_hit = wr && (addr == supply_mon_pkg::ADDR_PMSC);
  assign rd_hit = rd && (addr == supply_mon_pkg::ADDR_PMSC);
  // ==========================================================
  // control bits
  logic supply_warning_flag; // sticky flag
  logic supply_detect_reset_en; // write-once
  logic supply_detect_en; // write-once
  logic irq_en_ff; // plain read/write
  logic stop_en_ff;
  logic ref_buf_ff;
  logic nxt_irq_en;
  logic nxt_stop_en;
  logic nxt_ref_buf;
  // flag with ack, warning wins
  warn_flag u_flag (
    .clock(clock),
    .rst(rst),
    .warn_in(supply_warn_trip),
    .ack(wr_hit && wdata[supply_mon_pkg::BIT_WARN_ACK]),
    .flag(supply_warning_flag)
  );
  // reset enable, first write only
  write_once_bit #(.RST_VAL(supply_mon_pkg::RST_DET_RST_EN)) u_rst_en (
    .clock(clock),
    .rst(rst),
    .wr_en(wr_hit),
    .wr_bit(wdata[supply_mon_pkg::BIT_DET_RST_EN]),
    .q(supply_detect_reset_en)
  );
  // detect enable, first write only
  write_once_bit #(.RST_VAL(supply_mon_pkg::RST_DET_EN)) u_det_en (
    .clock(clock),
    .rst(rst),
    .wr_en(wr_hit),
    .wr_bit(wdata[supply_mon_pkg::BIT_DET_EN]),
    .q(supply_detect_en)
  );
  // read/write control bits
  always_comb begin
    nxt_irq_en = irq_en_ff;
    nxt_stop_en = stop_en_ff;
    nxt_ref_buf = ref_buf_ff;
    if (wr_hit) begin
      nxt_irq_en = wdata[supply_mon_pkg::BIT_WARN_IRQ_EN];
      nxt_stop_en = wdata[supply_mon_pkg::BIT_DET_STOP_EN];
      nxt_ref_buf = wdata[supply_mon_pkg::BIT_REF_BUF_EN];
    end
  end
  // register stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_en_ff <= supply_mon_pkg::RST_WARN_IRQ_EN;
      stop_en_ff <= supply_mon_pkg::RST_DET_STOP_EN;
      ref_buf_ff <= supply_mon_pkg::RST_REF_BUF_EN;
    end else begin
      irq_en_ff <= nxt_irq_en;
      stop_en_ff <= nxt_stop_en;
      ref_buf_ff <= nxt_ref_buf;
    end
  end
  // ==========================================================
  // outputs and read data
  logic det_live; // detection running now
  logic [supply_mon_pkg::DATA_W-1:0] rd_img; // register image
  logic [supply_mon_pkg::DATA_W-1:0] rdata_ff;
  logic irq_ff;
  logic reset_ff;
  logic active_ff;
  logic bgb_ff;
  logic [supply_mon_pkg::DATA_W-1:0] nxt_rdata;
  logic nxt_irq;
  logic nxt_reset;
  logic nxt_active;
  // detection on only when enabled, and in stop only if allowed
  assign det_live = supply_detect_en && (!stop_mode || stop_en_ff);
  // read image; ack and bit 1 read zero
  always_comb begin
    rd_img = supply_mon_pkg::ZERO_BYTE;
    rd_img[supply_mon_pkg::BIT_WARN_FLAG] = supply_warning_flag;
    rd_img[supply_mon_pkg::BIT_WARN_IRQ_EN] = irq_en_ff;
    rd_img[supply_mon_pkg::BIT_DET_RST_EN] = supply_detect_reset_en;
    rd_img[supply_mon_pkg::BIT_DET_STOP_EN] = stop_en_ff;
    rd_img[supply_mon_pkg::BIT_DET_EN] = supply_detect_en;
    rd_img[supply_mon_pkg::BIT_REF_BUF_EN] = ref_buf_ff;
  end
  // next values of the registered outputs
  always_comb begin
    nxt_rdata = rd_hit ? rd_img : supply_mon_pkg::ZERO_BYTE;
    nxt_irq = irq_en_ff && supply_warning_flag;
    nxt_reset = det_live && supply_detect_reset_en && supply_drop_detect;
    nxt_active = det_live;
  end
  // register stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_ff <= supply_mon_pkg::ZERO_BYTE;
      irq_ff <= 1'h0;
      reset_ff <= 1'h0;
      active_ff <= 1'h0;
      bgb_ff <= 1'h0;
    end else begin
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
      reset_ff <= nxt_reset;
      active_ff <= nxt_active;
      bgb_ff <= nxt_ref_buf;
    end
  end
  assign rdata = rdata_ff;
  assign supply_warning_irq = irq_ff;
  assign chip_reset_req = reset_ff;
  assign detect_active = active_ff;
  assign reference_buffer_en = bgb_ff;
endmodule
`default_nettype wire

// ### hw/supply_mon_pkg.sv
package supply_mon_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] ADDR_PMSC = 4'h0; // power monitor status/control
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // ==========================================================
  // bit positions
  localparam int BIT_WARN_FLAG = 7;
  localparam int BIT_WARN_ACK = 6;
  localparam int BIT_WARN_IRQ_EN = 5;
  localparam int BIT_DET_RST_EN = 4;
  localparam int BIT_DET_STOP_EN = 3;
  localparam int BIT_DET_EN = 2;
  localparam int BIT_REF_BUF_EN = 0;
  // ==========================================================
  // reset values of control bits
  localparam logic RST_WARN_IRQ_EN = 1'h0;
  localparam logic RST_DET_RST_EN = 1'h1;
  localparam logic RST_DET_STOP_EN = 1'h0;
  localparam logic RST_DET_EN = 1'h1;
  localparam logic RST_REF_BUF_EN = 1'h0;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
endpackage

// ### hw/warn_flag.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// sticky warning flag; a live warning wins over the acknowledge
module warn_flag (
  input wire logic clock,
  input wire logic rst,
  input wire logic warn_in,
  input wire logic ack,
  output logic flag
);
  logic flag_ff; // sticky flag
  logic nxt_flag;
  // set beats clear; after reset the live level sets it at once
  always_comb begin
    nxt_flag = flag_ff;
    if (ack) begin
      nxt_flag = 1'h0;
    end
    if (warn_in) begin
      nxt_flag = 1'h1;
    end
  end
  // register stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_ff <= 1'h0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end
  assign flag = flag_ff;
endmodule
`default_nettype wire

// ### hw/write_once_bit.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// control bit that takes only the first write after reset
module write_once_bit #(
  parameter logic RST_VAL = 1'h0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic wr_bit,
  output logic q
);
  logic q_ff; // stored value
  logic used_ff; // a write has already been taken
  logic nxt_q;
  logic nxt_used;
  // first write wins, later ones ignored
  always_comb begin
    nxt_q = q_ff;
    nxt_used = used_ff;
    if (wr_en && !used_ff) begin
      nxt_q = wr_bit;
      nxt_used = 1'h1;
    end
  end
  // register stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_ff <= RST_VAL;
      used_ff <= 1'h0;
    end else begin
      q_ff <= nxt_q;
      used_ff <= nxt_used;
    end
  end
  assign q = q_ff;
endmodule
`default_nettype wire

// ### tb/lv_detector_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// analog trip comparators: follow the commanded supply state
module lv_detector_model (
  input wire logic warn_cmd,
  input wire logic drop_cmd,
  output logic supply_warn_trip,
  output logic supply_drop_detect
);
  assign supply_warn_trip = warn_cmd;
  assign supply_drop_detect = drop_cmd;
endmodule
`default_nettype wire

// ### tb/lvd_ctl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checks of the supply monitor
module lvd_ctl_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic supply_warn_trip,
  input wire logic supply_drop_detect,
  input wire logic stop_mode,
  input wire logic supply_warning_irq,
  input wire logic chip_reset_req,
  input wire logic detect_active,
  input wire logic reference_buffer_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_flag_seen: assert property (rd && addr == 4'h0 && $past(supply_warn_trip) && !$past(rst)
    |=> rdata[7]) else $error("warning flag not seen");
  a_dead_bits: assert property (rd |=> rdata[6] == 1'b0 && rdata[1] == 1'b0)
    else $error("fixed bits not zero");
  a_idle_read: assert property (!rd || addr != 4'h0 |=> rdata == 8'h00)
    else $error("read data outside read");
  a_reset_cause: assert property (chip_reset_req |-> $past(supply_drop_detect))
    else $error("reset without detect");
  a_irq_rise: assert property ($rose(supply_warning_irq)
    |-> $past(supply_warn_trip, 2) || $past(wr, 2)) else $error("irq without cause");
  a_irq_fall: assert property ($fell(supply_warning_irq) |-> $past(wr, 2))
    else $error("irq dropped without write");
  a_buf_follow: assert property ($changed(reference_buffer_en) |-> $past(wr))
    else $error("buffer enable moved alone");
  a_stop_gate: assert property ($changed(detect_active) && !$past(rst, 2)
    |-> $past(wr, 2) || $past(stop_mode) != $past(stop_mode, 2)) else $error("detect moved alone");
  c_reset: cover property (chip_reset_req);
  c_irq: cover property (supply_warning_irq);
  c_stop: cover property (stop_mode && detect_active);
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
// ==========================================================
// register bus stimulus and checks
module tb;
  logic clock = 0, rst = 1, wr = 0, rd = 0, stop_mode = 0, warn_cmd = 0, drop_cmd = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic supply_warn_trip, supply_drop_detect, supply_warning_irq;
  logic chip_reset_req, detect_active, reference_buffer_en;
  int failures = 0, checked = 0;
  always #5 clock = ~clock;
  lv_detector_model far (.warn_cmd, .drop_cmd, .supply_warn_trip, .supply_drop_detect);
  low_voltage_detect_control uut (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .supply_warn_trip, .supply_drop_detect, .stop_mode, .supply_warning_irq,
    .chip_reset_req, .detect_active, .reference_buffer_en);
  task automatic close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one-cycle write strobe
  task automatic w(input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // one-cycle read, data checked in the following cycle
  task automatic r(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    addr <= 4'h0;
    #1 `CHK(rdata, e)
  endtask
  // let registered levels land
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    r(4'h0, 8'h14);
    @(posedge clock) warn_cmd <= 1'b1;
    settle;
    r(4'h0, 8'h94);
    w(8'h74);
    r(4'h0, 8'hB4);
    settle;
    `CHK(supply_warning_irq, 1'b1)
    @(posedge clock) warn_cmd <= 1'b0;
    w(8'h41);
    r(4'h0, 8'h15);
    settle;
    `CHK({supply_warning_irq, reference_buffer_en}, 2'b01)
    @(posedge clock) drop_cmd <= 1'b1;
    settle;
    `CHK(chip_reset_req, 1'b1)
    @(posedge clock) stop_mode <= 1'b1;
    settle;
    `CHK(detect_active, 1'b0)
    w(8'h0D);
    r(4'h0, 8'h1D);
    settle;
    `CHK({detect_active, chip_reset_req}, 2'b11)
    r(4'h3, 8'h00);
    // reset again while the supply is already low
    @(posedge clock) begin
      rst <= 1'b1;
      warn_cmd <= 1'b1;
      drop_cmd <= 1'b0;
      stop_mode <= 1'b0;
    end
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    r(4'h0, 8'h94);
    `CHK(detect_active, 1'b1)
    close_out;
  end
  // hang guard
  initial begin
    #100000;
    failures++;
    close_out;
  end
endmodule
bind low_voltage_detect_control lvd_ctl_asserts chk (.clock, .rst, .addr, .wdata, .wr, .rd,
  .rdata, .supply_warn_trip, .supply_drop_detect, .stop_mode, .supply_warning_irq,
  .chip_reset_req, .detect_active, .reference_buffer_en);
`default_nettype wire
